// ### logic/imc_pkg.sv
package imc_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_CMD = 5'h04;
	localparam logic [4:0] ADDR_DATA = 5'h08;
	localparam logic [4:0] ADDR_STAT = 5'h0C;
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h10;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h14;
	localparam logic [4:0] ADDR_BAUD = 5'h18;
	// ****************************************
	// Control fields
	// ****************************************
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_EN_BIT = 4;
	localparam int CTRL_DIR_SCL_BIT = 5;
	localparam int CTRL_DIR_SDA_BIT = 6;
	localparam logic [3:0] MODE_MASTER_HW = 4'h8;
	localparam logic [3:0] MODE_MASTER_FW = 4'hB;
	localparam logic [6:0] CTRL_RESET = 7'h60;
	// ****************************************
	// Command bits
	// ****************************************
	localparam int CMD_START = 0;
	localparam int CMD_RSTART = 1;
	localparam int CMD_STOP = 2;
	localparam int CMD_RECV = 3;
	localparam int CMD_ACK = 4;
	localparam int CMD_ACK_VAL = 5;
	// ****************************************
	// Status and interrupt bits
	// ****************************************
	localparam int ST_START_SEEN = 0;
	localparam int ST_STOP_SEEN = 1;
	localparam int ST_BUSY = 2;
	localparam int ST_WRITE_COLLISION_FLAG = 3;
	localparam int ST_ACK_IN = 4;
	localparam int ST_MASTER = 5;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_START_DET = 1;
	localparam int IRQ_STOP_DET = 2;
	localparam int IRQ_WRITE_COLLISION_FLAG = 3;
	localparam int IRQ_W = 4;
	// ****************************************
	// Timing, AXI responses and engine states
	// ****************************************
	localparam logic [15:0] BAUD_RESET = 16'h0004;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		ENG_IDLE, ENG_START_A, ENG_START_B, ENG_RS_A, ENG_RS_B,
		ENG_STOP_A, ENG_STOP_B, ENG_BIT_LO, ENG_BIT_HI, ENG_DONE
	} imc_eng_e;
endpackage : imc_pkg

// ### logic/imc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for bus line inputs
module imc_sync #(
	parameter int W = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_reg <= '1;
			q <= '1;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : imc_sync

// ### logic/imc_baud.sv
`timescale 1ns/1ps
// Baud tick divider, restarts on clear
module imc_baud (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clr,
	input wire logic [15:0] div,
	output logic tick
);
	logic [15:0] cnt_reg;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clr)
		begin
			cnt_reg <= 16'h0000;
			tick <= 1'b0;
		end
		else if (cnt_reg >= div)
		begin
			cnt_reg <= 16'h0000;
			tick <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule : imc_baud

// ### logic/imc_master.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - Master operation runs only with a master mode code and the enable bit set.
// R2 - In master operation the block drives both bus lines when both direction bits are inputs.
// R3 - Start and stop conditions on the bus are detected and each raises an interrupt event.
// R4 - Start-seen and stop-seen flags clear on reset and while the port is disabled.
// R5 - Software claims the bus only after a stop, or when idle with both flags clear.
// R6 - In firmware master mode software sequences every bus step from start and stop status.
// R7 - Software may request start, repeated start, byte send, receive, acknowledge or stop.
// R8 - Writing the data register while the bus engine is free sends that byte.
// R9 - On request an acknowledge bit is driven after a received byte.
// R10 - A data write during a running operation is dropped and the collision flag set.
// R11 - The interrupt flag is set when any operation finishes.
// R12 - Lines are driven open drain and all timing comes from the baud divider.
module imc_master (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	output logic irq
);
	// ****************************************
	// Declarations
	// ****************************************
	localparam int IRQ_W_L = imc_pkg::IRQ_W;
	logic [6:0] ctrl_reg;
	logic [15:0] baud_reg;
	logic [IRQ_W_L-1:0] mask_reg, ist_reg;
	logic [7:0] shift_reg, rx_reg;
	logic [3:0] bitn_reg;
	logic rx_mode_reg, ack_mode_reg, ack_val_reg, ack_in_reg;
	logic start_seen_reg, stop_seen_reg, write_collision_flag_reg, done_pulse;
	logic scl_drv_low, sda_drv_low, sda_late_reg;
	imc_pkg::imc_eng_e eng_reg;
	logic [4:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic aw_have_reg, w_have_reg;
	logic [1:0] line_s, line_d_reg;
	logic tick, master_on, pins_ok;
	logic wr_go, rd_go, wr_cmd, wr_data, rd_istat;
	logic start_det, stop_det;

	// ****************************************
	// Mode decode
	// ****************************************
	function automatic logic is_master(input logic [3:0] m);
		is_master = (m == imc_pkg::MODE_MASTER_HW) || (m == imc_pkg::MODE_MASTER_FW);
	endfunction : is_master

	// R1 mode and enable
	assign master_on = ctrl_reg[imc_pkg::CTRL_EN_BIT] &&
		is_master(ctrl_reg[imc_pkg::CTRL_MODE_LSB +: 4]);
	// R2 direction bits gate drive
	assign pins_ok = ctrl_reg[imc_pkg::CTRL_DIR_SCL_BIT] && ctrl_reg[imc_pkg::CTRL_DIR_SDA_BIT];

	imc_sync #(.W(2)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({scl_i, sda_i}),
		.q(line_s)
	);

	// R12 baud divider
	imc_baud u_baud (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(eng_reg == imc_pkg::ENG_IDLE),
		.div(baud_reg),
		.tick(tick)
	);

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign wr_cmd = wr_go && (awaddr_reg == imc_pkg::ADDR_CMD) && wdata_reg[7:0] != 8'h00;
	assign wr_data = wr_go && (awaddr_reg == imc_pkg::ADDR_DATA);
	assign rd_istat = rd_go && (s_axi_araddr == imc_pkg::ADDR_IRQ_STAT);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 5'h00;
			wdata_reg <= 32'h0000_0000;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= imc_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= {s_axi_awaddr[4:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				s_axi_wready <= 1'b0;
			end
			if (wr_go)
			begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg > imc_pkg::ADDR_BAUD) ?
					imc_pkg::RESP_SLVERR : imc_pkg::RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= imc_pkg::RESP_OKAY;
		end
		else if (rd_go)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= imc_pkg::RESP_OKAY;
			unique case ({s_axi_araddr[4:2], 2'b00})
				imc_pkg::ADDR_CTRL: s_axi_rdata <= {25'h0, ctrl_reg};
				imc_pkg::ADDR_CMD: s_axi_rdata <= {26'h0, ack_val_reg, ack_mode_reg,
					rx_mode_reg, 3'h0};
				imc_pkg::ADDR_DATA: s_axi_rdata <= {24'h0, rx_reg};
				imc_pkg::ADDR_STAT: s_axi_rdata <= {26'h0, master_on, ack_in_reg, write_collision_flag_reg,
					eng_reg != imc_pkg::ENG_IDLE, stop_seen_reg, start_seen_reg};
				imc_pkg::ADDR_IRQ_STAT: s_axi_rdata <= {28'h0, ist_reg};
				imc_pkg::ADDR_IRQ_MASK: s_axi_rdata <= {28'h0, mask_reg};
				imc_pkg::ADDR_BAUD: s_axi_rdata <= {16'h0, baud_reg};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= imc_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg <= imc_pkg::CTRL_RESET;
			baud_reg <= imc_pkg::BAUD_RESET;
			mask_reg <= '0;
		end
		else if (wr_go && s_axi_wstrb[0])
		begin
			if (awaddr_reg == imc_pkg::ADDR_CTRL)
				ctrl_reg <= wdata_reg[6:0];
			if (awaddr_reg == imc_pkg::ADDR_IRQ_MASK)
				mask_reg <= wdata_reg[IRQ_W_L-1:0];
			if (awaddr_reg == imc_pkg::ADDR_BAUD)
				baud_reg <= wdata_reg[15:0];
		end
	end

	// ****************************************
	// Bus condition detection
	// ****************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			line_d_reg <= 2'b11;
		else
			line_d_reg <= line_s;
	end
	// R3 SDA edge while SCL high
	assign start_det = line_s[1] && line_d_reg[1] && line_d_reg[0] && !line_s[0];
	assign stop_det = line_s[1] && line_d_reg[1] && !line_d_reg[0] && line_s[0];

	always_ff @(posedge aclk)
	begin
		// R4 clear on reset or disable
		if (!aresetn || !ctrl_reg[imc_pkg::CTRL_EN_BIT])
		begin
			start_seen_reg <= 1'b0;
			stop_seen_reg <= 1'b0;
		end
		else if (start_det)
		begin
			start_seen_reg <= 1'b1;
			stop_seen_reg <= 1'b0;
		end
		else if (stop_det)
		begin
			start_seen_reg <= 1'b0;
			stop_seen_reg <= 1'b1;
		end
	end

	// ****************************************
	// Bus engine
	// ****************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !master_on)
		begin
			eng_reg <= imc_pkg::ENG_IDLE;
			scl_drv_low <= 1'b0;
			sda_drv_low <= 1'b0;
			shift_reg <= 8'h00;
			rx_reg <= 8'h00;
			bitn_reg <= 4'h0;
			rx_mode_reg <= 1'b0;
			ack_mode_reg <= 1'b0;
			ack_val_reg <= 1'b0;
			ack_in_reg <= 1'b0;
			done_pulse <= 1'b0;
		end
		else
		begin
			done_pulse <= 1'b0;
			unique case (eng_reg)
				imc_pkg::ENG_IDLE:
				begin
					// R7 one request at a time
					if (wr_cmd && wdata_reg[imc_pkg::CMD_START])
					begin
						sda_drv_low <= 1'b0;
						eng_reg <= imc_pkg::ENG_START_A;
					end
					else if (wr_cmd && wdata_reg[imc_pkg::CMD_RSTART])
						eng_reg <= imc_pkg::ENG_RS_A;
					else if (wr_cmd && wdata_reg[imc_pkg::CMD_STOP])
					begin
						sda_drv_low <= 1'b1;
						eng_reg <= imc_pkg::ENG_STOP_A;
					end
					else if (wr_cmd && wdata_reg[imc_pkg::CMD_RECV])
					begin
						rx_mode_reg <= 1'b1;
						ack_mode_reg <= 1'b0;
						sda_drv_low <= 1'b0;
						bitn_reg <= 4'h8;
						eng_reg <= imc_pkg::ENG_BIT_LO;
					end
					// R9 acknowledge bit after receive
					else if (wr_cmd && wdata_reg[imc_pkg::CMD_ACK])
					begin
						rx_mode_reg <= 1'b0;
						ack_mode_reg <= 1'b1;
						ack_val_reg <= wdata_reg[imc_pkg::CMD_ACK_VAL];
						sda_drv_low <= !wdata_reg[imc_pkg::CMD_ACK_VAL];
						bitn_reg <= 4'h1;
						eng_reg <= imc_pkg::ENG_BIT_LO;
					end
					// R8 data write sends byte
					else if (wr_data)
					begin
						rx_mode_reg <= 1'b0;
						ack_mode_reg <= 1'b0;
						shift_reg <= wdata_reg[7:0];
						sda_drv_low <= !wdata_reg[7];
						bitn_reg <= 4'h9;
						eng_reg <= imc_pkg::ENG_BIT_LO;
					end
				end
				imc_pkg::ENG_START_A:
					if (tick)
					begin
						sda_drv_low <= 1'b1;
						eng_reg <= imc_pkg::ENG_START_B;
					end
				imc_pkg::ENG_START_B:
					if (tick)
					begin
						scl_drv_low <= 1'b1;
						eng_reg <= imc_pkg::ENG_DONE;
					end
				imc_pkg::ENG_RS_A:
					if (tick)
					begin
						sda_drv_low <= 1'b0;
						scl_drv_low <= 1'b0;
						eng_reg <= imc_pkg::ENG_START_A;
					end
				imc_pkg::ENG_RS_B:
					eng_reg <= imc_pkg::ENG_START_A;
				imc_pkg::ENG_STOP_A:
					if (tick)
					begin
						scl_drv_low <= 1'b0;
						eng_reg <= imc_pkg::ENG_STOP_B;
					end
				imc_pkg::ENG_STOP_B:
					if (tick)
					begin
						sda_drv_low <= 1'b0;
						eng_reg <= imc_pkg::ENG_DONE;
					end
				imc_pkg::ENG_BIT_LO:
					if (tick)
					begin
						scl_drv_low <= 1'b0;
						eng_reg <= imc_pkg::ENG_BIT_HI;
					end
				imc_pkg::ENG_BIT_HI:
					if (tick && line_s[1])
					begin
						scl_drv_low <= 1'b1;
						bitn_reg <= bitn_reg - 4'h1;
						if (rx_mode_reg)
							rx_reg <= {rx_reg[6:0], line_s[0]};
						else if (!ack_mode_reg && bitn_reg == 4'h1)
							ack_in_reg <= line_s[0];
						shift_reg <= {shift_reg[6:0], 1'b1};
						if (bitn_reg == 4'h1)
						begin
							sda_drv_low <= 1'b0;
							eng_reg <= imc_pkg::ENG_DONE;
						end
						else
						begin
							sda_drv_low <= !rx_mode_reg && !shift_reg[6] && bitn_reg != 4'h2;
							eng_reg <= imc_pkg::ENG_BIT_LO;
						end
					end
				imc_pkg::ENG_DONE:
				begin
					// R11 completion event
					done_pulse <= 1'b1;
					eng_reg <= imc_pkg::ENG_IDLE;
				end
				default: eng_reg <= imc_pkg::ENG_IDLE;
			endcase
		end
	end

	// ****************************************
	// Collision and interrupts
	// ****************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			write_collision_flag_reg <= 1'b0;
		// R10 drop write while busy
		else if (wr_data && eng_reg != imc_pkg::ENG_IDLE)
			write_collision_flag_reg <= 1'b1;
		else if (wr_go && awaddr_reg == imc_pkg::ADDR_STAT)
			write_collision_flag_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ist_reg <= '0;
		else
			ist_reg <= (rd_istat ? '0 : ist_reg) |
				{(wr_data && eng_reg != imc_pkg::ENG_IDLE), stop_det, start_det, done_pulse};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(ist_reg & mask_reg);
	end

	// ****************************************
	// Open-drain pins
	// ****************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			sda_late_reg <= 1'b0;
		end
		else
		begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			// Data moves a cycle after the clock falls
			sda_late_reg <= sda_drv_low;
			// R12 pull low or release
			scl_oe_n <= !(master_on && pins_ok && scl_drv_low);
			sda_oe_n <= !(master_on && pins_ok && sda_late_reg);
		end
	end
endmodule : imc_master

// ### verif/imc_master_assertions.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module imc_master_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scl_o,
	input wire logic scl_oe_n,
	input wire logic sda_o,
	input wire logic sda_oe_n,
	input wire logic irq
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read data late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	drive_low_a: assert property (!scl_o && !sda_o)
		else $error("bus line driven high");
	scl_low_a: assert property ($fell(scl_oe_n) |=> !scl_oe_n[*3])
		else $error("clock low phase short");
	scl_high_a: assert property ($rose(scl_oe_n) |=> scl_oe_n[*3])
		else $error("clock high phase short");
	sda_setup_a: assert property ($fell(scl_oe_n) |-> $stable(sda_oe_n))
		else $error("data line moved with clock fall");
	irq_hold_a: assert property (irq && !s_axi_arvalid && !s_axi_awvalid && !s_axi_rvalid
		&& !s_axi_bvalid |=> irq)
		else $error("interrupt dropped without access");
endmodule : imc_master_chk

bind imc_master imc_master_chk i_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq));

// ### verif/imc_slave_model.sv
`timescale 1ns/1ps
// ****
// Bus target model
// ****
module imc_slave_model #(
	parameter logic [7:0] TX_BYTE = 8'h96
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack,
	input wire logic stretch,
	output logic scl_low,
	output logic sda_low
);
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic act = 1'b0;
	logic rd = 1'b0;
	logic first = 1'b0;
	logic mack = 1'b1;
	logic [7:0] sh = 8'h00;
	int cnt = 0;
	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	always @(scl or sda)
	begin
		if (scl && scl_q && sda != sda_q)
		begin
			act = !sda;
			cnt = 0;
			first = 1'b1;
			rd = 1'b0;
		end
		else if (scl && !scl_q && act)
		begin
			cnt = cnt + 1;
			if (cnt < 9)
				sh = {sh[6:0], sda};
			else if (rd && !first)
			begin
				mack = sda;
				rd = !sda;
			end
		end
		else if (!scl && scl_q && act)
		begin
			sda_low = 1'b0;
			if (cnt == 8 && first)
				rd = sh[0];
			if (cnt == 8 && (first || !rd))
				sda_low = !nack;
			if (cnt == 9)
			begin
				cnt = 0;
				first = 1'b0;
			end
			if (rd && !first && cnt < 8)
				sda_low = !TX_BYTE[7 - cnt];
		end
		scl_q = scl;
		sda_q = sda;
	end
	// Slow answer: hold clock low after a byte
	always @(negedge scl)
		if (stretch && act && cnt == 8)
		begin
			scl_low = 1'b1;
			#1500;
			scl_low = 1'b0;
		end
endmodule : imc_slave_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	// ****
	// Signals and instances
	// ****
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [4:0] awaddr = 5'h00;
	logic [4:0] araddr = 5'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic nack = 1'b0;
	logic stretch = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic scl_o, scl_oe_n, sda_o, sda_oe_n, scl_low, sda_low, scl, sda;
	logic [31:0] cfg [4] = '{32'h0000_0070, 32'h0000_0068, 32'h0000_007B, 32'h0000_0078};
	int n_mismatch = 0;
	int check_count = 0;
	assign scl = scl_oe_n & ~scl_low;
	assign sda = sda_oe_n & ~sda_low;
	initial forever #50 aclk = ~aclk;
	imc_master i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq));
	imc_slave_model i_slv (.scl(scl), .sda(sda), .nack(nack), .stretch(stretch),
		.scl_low(scl_low), .sda_low(sda_low));
	// ****
	// Tasks
	// ****
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	task automatic hang();
		n_mismatch++;
		$display("BAD wait exp done got timeout");
		close_out();
	endtask : hang
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid && n < 200);
		bready <= 1'b0;
		@(posedge aclk);
		if (n >= 200)
			hang();
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid && n < 200);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		@(posedge aclk);
		if (n >= 200)
			hang();
	endtask : rd
	task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(nm, e, d & m);
	endtask : rchk
	task automatic idle();
		logic [31:0] d;
		logic [1:0] r;
		int n;
		n = 0;
		do
		begin
			rd(imc_pkg::ADDR_STAT, d, r);
			n++;
		end while (d[imc_pkg::ST_BUSY] !== 1'b0 && n < 500);
		if (n >= 500)
			hang();
	endtask : idle
	task automatic op(input logic [4:0] a, input logic [31:0] d);
		wr(a, d);
		idle();
	endtask : op
	// ****
	// Tests
	// ****
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk("ctrl", imc_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0060);
		rchk("baud", imc_pkg::ADDR_BAUD, 32'hFFFF_FFFF, 32'h0000_0004);
		rchk("flags", imc_pkg::ADDR_STAT, 32'h0000_0003, 32'h0000_0000);
		rd(5'h1C, d, r);
		chk("resp", 32'(imc_pkg::RESP_SLVERR), 32'(r));
		wr(5'h1C, 32'h0000_0000);
		chk("bresp", 32'(imc_pkg::RESP_SLVERR), 32'(bresp));
		$display("test reset done");
		wr(imc_pkg::ADDR_BAUD, 32'h0000_0003);
		wr(imc_pkg::ADDR_IRQ_MASK, 32'h0000_000F);
		for (int i = 0; i < 4; i++)
		begin
			wr(imc_pkg::ADDR_CTRL, cfg[i]);
			rchk("master", imc_pkg::ADDR_STAT, 32'h20, (i >= 2) ? 32'h20 : 32'h0);
		end
		$display("test mode done");
		wr(imc_pkg::ADDR_CMD, 32'h0000_0001);
		wr(imc_pkg::ADDR_DATA, 32'h0000_00A0);
		rchk("write_collision_flag", imc_pkg::ADDR_STAT, 32'h0000_0008, 32'h0000_0008);
		idle();
		chk("irq", 32'h0000_0001, 32'(irq));
		rchk("events", imc_pkg::ADDR_IRQ_STAT, 32'h0000_000F, 32'h0000_000B);
		repeat (2) @(posedge aclk);
		chk("irq", 32'h0000_0000, 32'(irq));
		wr(imc_pkg::ADDR_STAT, 32'h0000_0000);
		rchk("started", imc_pkg::ADDR_STAT, 32'h0000_0009, 32'h0000_0001);
		$display("test start done");
		op(imc_pkg::ADDR_DATA, 32'h0000_00A0);
		chk("addr", 32'h0000_00A0, 32'(i_slv.sh));
		rchk("ack", imc_pkg::ADDR_STAT, 32'h0000_0010, 32'h0000_0000);
		rchk("done", imc_pkg::ADDR_IRQ_STAT, 32'h0000_000F, 32'h0000_0001);
		stretch <= 1'b1;
		op(imc_pkg::ADDR_DATA, 32'h0000_005C);
		stretch <= 1'b0;
		chk("data", 32'h0000_005C, 32'(i_slv.sh));
		$display("test send done");
		op(imc_pkg::ADDR_CMD, 32'h0000_0002);
		op(imc_pkg::ADDR_DATA, 32'h0000_00A1);
		op(imc_pkg::ADDR_CMD, 32'h0000_0008);
		rchk("rx", imc_pkg::ADDR_DATA, 32'h0000_00FF, 32'h0000_0096);
		op(imc_pkg::ADDR_CMD, 32'h0000_0010);
		chk("mack", 32'h0000_0000, 32'(i_slv.mack));
		op(imc_pkg::ADDR_CMD, 32'h0000_0008);
		rchk("rx", imc_pkg::ADDR_DATA, 32'h0000_00FF, 32'h0000_0096);
		op(imc_pkg::ADDR_CMD, 32'h0000_0030);
		chk("mnack", 32'h0000_0001, 32'(i_slv.mack));
		op(imc_pkg::ADDR_CMD, 32'h0000_0004);
		rchk("stopped", imc_pkg::ADDR_STAT, 32'h0000_0002, 32'h0000_0002);
		rchk("stop ev", imc_pkg::ADDR_IRQ_STAT, 32'h0000_0005, 32'h0000_0005);
		$display("test receive done");
		wr(imc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
		nack <= 1'b1;
		op(imc_pkg::ADDR_CMD, 32'h0000_0001);
		op(imc_pkg::ADDR_DATA, 32'h0000_0042);
		rchk("nacked", imc_pkg::ADDR_STAT, 32'h0000_0010, 32'h0000_0010);
		chk("masked", 32'h0000_0000, 32'(irq));
		rchk("done", imc_pkg::ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
		op(imc_pkg::ADDR_CMD, 32'h0000_0004);
		nack <= 1'b0;
		wr(imc_pkg::ADDR_CTRL, 32'h0000_0068);
		rchk("cleared", imc_pkg::ADDR_STAT, 32'h0000_0003, 32'h0000_0000);
		wr(imc_pkg::ADDR_CTRL, 32'h0000_0018);
		op(imc_pkg::ADDR_CMD, 32'h0000_0001);
		chk("no start", 32'h0000_0000, 32'(i_slv.act));
		$display("test mask and disable done");
		close_out();
	end
endmodule : tb_top
